/* File: common/pspc_pkg.sv */
// constants, field positions and state encoding of the load converter sequencer
// assumes all codes are in 12.5 mV setpoint units and delays in master clock ticks
package pspc_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int VW = 9;
  localparam int DW = 16;
  localparam int TW = 8;
  localparam int PW = 25;

  // ************************************************************
  // protection_config_one fields
  // ************************************************************
  localparam int CFG1_OC_LATCH = 0;
  localparam int CFG1_UV_LATCH = 1;
  localparam int CFG1_OT_LATCH = 2;
  localparam int CFG1_TR_LATCH = 3;
  localparam int CFG1_TR_EN = 4;

  // ************************************************************
  // protection_config_two fields
  // ************************************************************
  localparam int CFG2_PG_LOW95 = 7;
  localparam int CFG2_UV_PCT_HI = 6;

  // ************************************************************
  // protection_config_three and current limit fields
  // ************************************************************
  localparam int CFG3_PT_REPORT = 0;
  localparam int CFG3_PG_REPORT = 1;
  localparam int CLS_TCOMP_EN = 7;

  // ************************************************************
  // status vector, active low, bit positions
  // ************************************************************
  localparam int FL_PT = 0;
  localparam int FL_PG = 1;
  localparam int FL_OC = 2;
  localparam int FL_UV = 3;
  localparam int FL_OT = 4;
  localparam int FL_TR = 5;
  localparam int FLW = 6;
  localparam logic [FLW-1:0] FLAGS_RESET = 6'h3F;

  // ************************************************************
  // thresholds
  // ************************************************************
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [7:0] PCT_PG_HIGH = 8'h6E;
  localparam logic [7:0] PCT_PG_LOW90 = 8'h5A;
  localparam logic [7:0] PCT_PG_LOW95 = 8'h5F;
  localparam logic [VW-1:0] TRACK_LIMIT = 9'h014;
  localparam logic signed [TW-1:0] TEMP_WARN_SET = 8'sh78;
  localparam logic signed [TW-1:0] TEMP_WARN_CLR = 8'sh75;
  localparam logic signed [TW-1:0] TEMP_OT_SET = 8'sh78;
  localparam logic signed [TW-1:0] TEMP_OT_RESTART = 8'sh6E;

  // ************************************************************
  // timing
  // ************************************************************
  localparam longint CLK_HZ = 40000000;
  localparam longint HICCUP_MS = 130;
  localparam longint HICCUP_CYCLES = (HICCUP_MS * CLK_HZ) / 1000;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON_WAIT,
    ST_RISE,
    ST_STEADY,
    ST_OFF_WAIT,
    ST_FALL,
    ST_HICCUP,
    ST_LATCHED
  } pspc_state_e;

endpackage

/* File: hdl/pspc_sequencer.sv */
// sequencing, slew ramp and protection state machine of one load converter
// assumes all inputs synchronous to clk_sys; mclk_tick is one pulse per master clock edge
`timescale 1ns/10ps
module pspc_sequencer
  import pspc_pkg::*;
#(
  parameter longint HICCUP_CNT = HICCUP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // commands from the power manager
  input wire logic mclk_tick,
  input wire logic turn_on_req,
  input wire logic status_clear,
  // configuration
  input wire logic [DW-1:0] start_delay,
  input wire logic [DW-1:0] stop_delay,
  input wire logic [DW-1:0] ramp_rate_rise,
  input wire logic [DW-1:0] ramp_rate_fall,
  input wire logic [VW-1:0] vout_setpoint,
  input wire logic [7:0] protection_config_one,
  input wire logic [7:0] protection_config_two,
  input wire logic [7:0] protection_config_three,
  input wire logic [7:0] current_limit_cfg,
  // measurements from the power stage
  input wire logic [VW-1:0] vout_meas,
  input wire logic [VW-1:0] prebias_meas,
  input wire logic current_at_limit,
  input wire logic signed [TW-1:0] temp_meas,
  // open-drain power-ok pin
  input wire logic power_ok_in,
  output logic power_ok_out,
  output logic power_ok_oe,
  // power stage control
  output logic [VW-1:0] setpoint_ramp,
  output logic switches_on,
  output logic tcomp_enable,
  // status
  output logic [FLW-1:0] fault_flag,
  output logic alert_out,
  output logic steady_state
);

  // ************************************************************
  // state
  // ************************************************************
  pspc_state_e state_reg, state_next;
  logic [VW-1:0] ramp_reg, ramp_next;
  logic [DW-1:0] step_cnt_reg, step_cnt_next;
  logic [PW-1:0] dly_cnt_reg, dly_cnt_next;
  logic [31:0] hic_cnt_reg, hic_cnt_next;
  logic sw_reg, sw_next;
  logic fault_pend_reg, fault_pend_next;
  logic [3:0] kind_reg, kind_next;
  logic on_prev_reg;
  logic cycled_reg, cycled_next;
  logic [FLW-1:0] fault_flag_reg;
  logic temp_warn_reg;
  logic pg_drive_reg;
  logic alert_reg;
  logic tcomp_reg;

  // ************************************************************
  // decode
  // ************************************************************
  wire on_rise = turn_on_req & ~on_prev_reg;
  wire on_fall = ~turn_on_req & on_prev_reg;
  wire [PW-1:0] ramp_time = PW'(ramp_reg) * PW'(ramp_rate_fall);
  wire fall_slew = ramp_rate_fall != '0;
  // stop delay shorter than the ramp leaves no wait at all
  wire [PW-1:0] off_wait = !fall_slew ? PW'(stop_delay) :
                           (PW'(stop_delay) > ramp_time) ? PW'(stop_delay) - ramp_time : '0;
  wire [PW-1:0] on_wait = PW'(start_delay);
  wire [DW-1:0] hold_sel = (state_reg == ST_FALL) ? ramp_rate_fall : ramp_rate_rise;
  // each code stands hold_sel ticks, so the fall time matches the off-wait reckoning
  wire [DW-1:0] hold_last = (hold_sel == '0) ? '0 : hold_sel - 16'h0001;
  wire step_due = mclk_tick && (step_cnt_reg >= hold_last);
  wire dly_done = dly_cnt_reg >= ((state_reg == ST_ON_WAIT) ? on_wait : off_wait);

  // thresholds scale with the live setpoint, so margining moves them too
  wire [15:0] vout_x100 = 16'(vout_meas) * 16'(PCT_FULL);
  wire [7:0] uv_pct = {1'b0, protection_config_two[CFG2_UV_PCT_HI:0]};
  wire [7:0] pg_lo_pct = protection_config_two[CFG2_PG_LOW95] ? PCT_PG_LOW95 : PCT_PG_LOW90;
  wire [15:0] uv_thr = 16'(vout_setpoint) * 16'(uv_pct);
  wire [15:0] pg_hi_thr = 16'(vout_setpoint) * 16'(PCT_PG_HIGH);
  wire [15:0] pg_lo_thr = 16'(vout_setpoint) * 16'(pg_lo_pct);
  wire below_uv = vout_x100 < uv_thr;
  wire in_window = (vout_x100 <= pg_hi_thr) && (vout_x100 >= pg_lo_thr);

  wire running = sw_reg;
  wire settled = (state_reg == ST_STEADY) && (ramp_reg == vout_setpoint);
  wire [VW-1:0] trk_diff = (vout_meas > ramp_reg) ? vout_meas - ramp_reg : ramp_reg - vout_meas;

  wire oc_trip = running && current_at_limit && (vout_meas > prebias_meas) && below_uv;
  wire tr_trip = running && (state_reg == ST_RISE) && protection_config_one[CFG1_TR_EN] &&
                 (trk_diff > TRACK_LIMIT);
  wire uv_trip = settled && below_uv && !oc_trip;
  wire ot_hot = temp_meas > TEMP_OT_SET;
  wire ot_trip = running && ot_hot && !fault_pend_reg;
  wire fast_trip = oc_trip || tr_trip;
  wire slow_trip = (uv_trip || ot_trip) && !fault_pend_reg;
  wire [3:0] trip_vec = {tr_trip, ot_trip, uv_trip, oc_trip};

  // overcurrent and overtemperature wait for their cause to clear, undervoltage and tracking do not; overtemperature needs the lower threshold
  wire cond_gone = !(kind_reg[0] && current_at_limit) &&
                   !(kind_reg[2] && (temp_meas >= TEMP_OT_RESTART));
  wire any_latch = |(kind_reg & protection_config_one[CFG1_TR_LATCH:CFG1_OC_LATCH]);
  wire hic_done = hic_cnt_reg >= 32'(HICCUP_CNT - 1);

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    ramp_next = ramp_reg;
    step_cnt_next = mclk_tick ? step_cnt_reg + 16'h0001 : step_cnt_reg;
    dly_cnt_next = mclk_tick ? dly_cnt_reg + 25'h0000001 : dly_cnt_reg;
    hic_cnt_next = '0;
    sw_next = sw_reg;
    fault_pend_next = fault_pend_reg;
    kind_next = kind_reg | trip_vec;
    cycled_next = cycled_reg | on_fall;
    if (step_due) begin
      step_cnt_next = '0;
    end
    case (state_reg)
      ST_OFF: begin
        if (on_rise) begin
          state_next = ST_ON_WAIT;
          dly_cnt_next = '0;
        end
      end
      ST_ON_WAIT: begin
        if (!turn_on_req) begin
          state_next = ST_OFF;
        end else if (dly_done) begin
          state_next = ST_RISE;
          sw_next = 1'b1;
          step_cnt_next = '0;
        end
      end
      ST_RISE, ST_STEADY: begin
        if (step_due && ramp_reg < vout_setpoint) begin
          ramp_next = ramp_reg + 9'h001;
        end else if (step_due && ramp_reg > vout_setpoint) begin
          ramp_next = ramp_reg - 9'h001;
        end
        if (state_reg == ST_RISE && ramp_reg == vout_setpoint) begin
          state_next = ST_STEADY;
        end
        if (slow_trip || !turn_on_req) begin
          state_next = ST_OFF_WAIT;
          fault_pend_next = slow_trip;
          dly_cnt_next = '0;
        end
      end
      ST_OFF_WAIT: begin
        if (dly_done) begin
          if (fall_slew) begin
            state_next = ST_FALL;
            step_cnt_next = '0;
          end else begin
            sw_next = 1'b0;
            ramp_next = '0;
            state_next = fault_pend_reg ? ST_HICCUP : ST_OFF;
          end
        end
      end
      ST_FALL: begin
        if (ramp_reg == '0) begin
          sw_next = 1'b0;
          state_next = fault_pend_reg ? ST_HICCUP : ST_OFF;
        end else if (step_due) begin
          ramp_next = ramp_reg - 9'h001;
        end
      end
      ST_HICCUP: begin
        hic_cnt_next = hic_cnt_reg + 32'h00000001;
        cycled_next = 1'b0;
        if (hic_done) begin
          hic_cnt_next = hic_cnt_reg;
          if (any_latch) begin
            state_next = ST_LATCHED;
          end else if (cond_gone && turn_on_req) begin
            state_next = ST_ON_WAIT;
            dly_cnt_next = '0;
            fault_pend_next = 1'b0;
            kind_next = '0;
          end else if (cond_gone) begin
            state_next = ST_OFF;
            fault_pend_next = 1'b0;
            kind_next = '0;
          end
        end
      end
      ST_LATCHED: begin
        if (cond_gone && ((status_clear && turn_on_req) || (on_rise && cycled_reg))) begin
          state_next = ST_ON_WAIT;
          dly_cnt_next = '0;
          fault_pend_next = 1'b0;
          kind_next = '0;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    // fast faults open both switches at once, from any live state
    if (fast_trip) begin
      sw_next = 1'b0;
      ramp_next = '0;
      fault_pend_next = 1'b1;
      state_next = ST_HICCUP;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_OFF;
      ramp_reg <= '0;
      step_cnt_reg <= '0;
      dly_cnt_reg <= '0;
      hic_cnt_reg <= '0;
      sw_reg <= 1'b0;
      fault_pend_reg <= 1'b0;
      kind_reg <= '0;
      on_prev_reg <= 1'b0;
      cycled_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ramp_reg <= ramp_next;
      step_cnt_reg <= step_cnt_next;
      dly_cnt_reg <= dly_cnt_next;
      hic_cnt_reg <= hic_cnt_next;
      sw_reg <= sw_next;
      fault_pend_reg <= fault_pend_next;
      kind_reg <= kind_next;
      on_prev_reg <= turn_on_req;
      cycled_reg <= cycled_next;
    end
  end

  // ************************************************************
  // status flags and warnings
  // ************************************************************
  // hysteresis keeps the warning from chattering around one threshold
  wire temp_warn_next = (temp_meas > TEMP_WARN_SET) ? 1'b1 :
                        (temp_meas < TEMP_WARN_CLR) ? 1'b0 : temp_warn_reg;
  wire pg_bad = settled && !in_window;
  wire pg_ext_low = !power_ok_in && !pg_drive_reg;
  wire restart_ok = state_next == ST_ON_WAIT && state_reg != ST_OFF && state_reg != ST_ON_WAIT;
  // a trip in the clearing cycle wins over the clear
  wire [3:0] fault_keep = (status_clear || restart_ok) ? 4'h0 : ~fault_flag_reg[FL_TR:FL_OC];
  wire [3:0] fault_low_next = fault_keep | trip_vec;
  wire alert_next = (protection_config_three[CFG3_PT_REPORT] && temp_warn_next) ||
                    (protection_config_three[CFG3_PG_REPORT] && (pg_bad || pg_ext_low));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fault_flag_reg <= FLAGS_RESET;
      temp_warn_reg <= 1'b0;
      pg_drive_reg <= 1'b1;
      alert_reg <= 1'b0;
      tcomp_reg <= 1'b0;
    end else begin
      temp_warn_reg <= temp_warn_next;
      fault_flag_reg[FL_PT] <= ~temp_warn_next;
      fault_flag_reg[FL_PG] <= ~(pg_bad || pg_ext_low);
      fault_flag_reg[FL_TR:FL_OC] <= ~fault_low_next;
      pg_drive_reg <= !settled || !in_window;
      alert_reg <= alert_next;
      tcomp_reg <= current_limit_cfg[CLS_TCOMP_EN];
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign power_ok_out = 1'b0;
  assign power_ok_oe = pg_drive_reg;
  assign setpoint_ramp = ramp_reg;
  assign switches_on = sw_reg;
  assign tcomp_enable = tcomp_reg;
  assign fault_flag = fault_flag_reg;
  assign alert_out = alert_reg;
  assign steady_state = settled;

endmodule

/* File: tb/pspc_chk.sv */
// concurrent checks on the sequencer ports
// assumes a bind onto pspc_sequencer, one clock domain
`timescale 1ns/10ps
module pspc_chk
  import pspc_pkg::*;
#(
  parameter longint HICCUP_CNT = HICCUP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // inputs watched
  input wire logic mclk_tick,
  input wire logic current_at_limit,
  input wire logic [VW-1:0] vout_meas,
  input wire logic [VW-1:0] prebias_meas,
  input wire logic [VW-1:0] vout_setpoint,
  input wire logic [7:0] protection_config_two,
  input wire logic [7:0] protection_config_three,
  input wire logic signed [TW-1:0] temp_meas,
  // outputs watched
  input wire logic power_ok_oe,
  input wire logic [VW-1:0] setpoint_ramp,
  input wire logic switches_on,
  input wire logic [FLW-1:0] fault_flag,
  input wire logic alert_out,
  input wire logic steady_state
);
  // ********
  // thresholds times 100, one percent guard band
  // ********
  wire [17:0] v100 = 18'(vout_meas) * 18'h00064;
  wire [17:0] sp1 = 18'(vout_setpoint);
  wire [17:0] pg_lo = sp1 * (protection_config_two[7] ? 18'h0005F : 18'h0005A);
  wire uv_lo = (v100 + sp1) < sp1 * 18'(protection_config_two[6:0]);
  wire pg_out = (v100 > sp1 * 18'h0006F) || ((v100 + sp1) < pg_lo);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_pg_transition: assert property ((!steady_state) [*2] |-> power_ok_oe)
    else $error("power-ok released outside steady state");
  a_ramp_step: assert property (($changed(setpoint_ramp) && setpoint_ramp != 9'h000) |->
    $past(mclk_tick) && (setpoint_ramp == $past(setpoint_ramp) + 9'h001 ||
    setpoint_ramp + 9'h001 == $past(setpoint_ramp)))
    else $error("ramp moved by more than one code or off a tick");
  a_off_at_zero: assert property ($fell(switches_on) |-> ##[0:1] setpoint_ramp == 9'h000)
    else $error("switches opened with ramp above zero");
  a_oc_fast_off: assert property ((switches_on && current_at_limit && uv_lo &&
    vout_meas > prebias_meas) |=> !switches_on && !fault_flag[FL_OC])
    else $error("overcurrent did not open switches at once");
  a_warn_set: assert property (temp_meas > 8'sh78 |=> !fault_flag[FL_PT])
    else $error("temperature warning not raised");
  a_warn_clear: assert property (temp_meas < 8'sh75 |=> fault_flag[FL_PT])
    else $error("temperature warning not released");
  a_ot_set: assert property (temp_meas > 8'sh78 |=> !fault_flag[FL_OT])
    else $error("overtemperature fault not flagged");
  a_pg_window: assert property ((steady_state && $past(steady_state) && pg_out && !uv_lo)
    |=> !fault_flag[FL_PG] && power_ok_oe)
    else $error("power good window miss not flagged");
  a_alert_warn: assert property ((!fault_flag[FL_PT] && protection_config_three[0])
    |-> ##[0:2] alert_out)
    else $error("reported warning gave no alert");

  c_steady: cover property (steady_state);
  c_oc: cover property (!fault_flag[FL_OC]);
  c_track: cover property (!fault_flag[FL_TR]);
endmodule

bind pspc_sequencer pspc_chk #(.HICCUP_CNT(HICCUP_CNT)) u_chk (.clk_sys, .arst_n,
  .mclk_tick, .current_at_limit, .vout_meas, .prebias_meas, .vout_setpoint,
  .protection_config_two, .protection_config_three, .temp_meas, .power_ok_oe,
  .setpoint_ramp, .switches_on, .fault_flag, .alert_out, .steady_state);

/* File: tb/pspc_mgr_model.sv */
// power manager and a crude output plant
// assumes the bench calls set_on, clear_pulse and sets offs
`timescale 1ns/10ps
module pspc_mgr_model
  import pspc_pkg::*;
#(
  parameter int TICK_DIV = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // manager side
  output logic mclk_tick,
  output logic turn_on_req,
  output logic status_clear,
  // plant side
  input wire logic [VW-1:0] setpoint_ramp,
  input wire logic switches_on,
  output logic [VW-1:0] vout_meas
);
  int div_cnt = 0;
  int offs = 0;
  logic on_cmd = 1'b0;
  logic clr_cmd = 1'b0;

  function automatic logic [VW-1:0] plant(logic [VW-1:0] s, int o);
    int v = int'(s) + o;
    if (v < 0) v = 0;
    if (v > 511) v = 511;
    return VW'(v);
  endfunction

  task automatic set_on(input logic v);
    on_cmd = v;
  endtask

  task automatic clear_pulse();
    clr_cmd = 1'b1;
  endtask

  initial begin
    mclk_tick = 1'b0;
    turn_on_req = 1'b0;
    status_clear = 1'b0;
    vout_meas = 9'h000;
  end

  // free running master clock divided down, all outputs move on falling edge
  always @(negedge clk_sys) begin
    div_cnt = (div_cnt + 1) % TICK_DIV;
    mclk_tick <= (div_cnt == 0);
    turn_on_req <= on_cmd;
    status_clear <= clr_cmd;
    clr_cmd = 1'b0;
    // open switches: load pulls output to zero
    vout_meas <= switches_on ? plant(setpoint_ramp, offs) : 9'h000;
  end
endmodule

/* File: tb/tb_pspc_sequencer.sv */
// self-checking bench of the sequencer
// assumes pspc_mgr_model as manager and plant, short hiccup
`timescale 1ns/10ps
module tb_pspc_sequencer;
  import pspc_pkg::*;
  localparam int DIV = 4;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic mclk_tick, turn_on_req, status_clear, power_ok_out, power_ok_oe;
  logic switches_on, tcomp_enable, alert_out, steady_state;
  logic current_at_limit = 1'b0;
  logic ext_low = 1'b0;
  logic [DW-1:0] start_delay, stop_delay, ramp_rate_rise, ramp_rate_fall;
  logic [VW-1:0] vout_setpoint, vout_meas, setpoint_ramp;
  logic [VW-1:0] prebias_meas = 9'h000;
  logic [7:0] protection_config_one, protection_config_two, protection_config_three;
  logic [7:0] current_limit_cfg;
  logic signed [TW-1:0] temp_meas = 8'sh19;
  logic [FLW-1:0] fault_flag;
  int n_mismatch = 0;
  int samples_checked = 0;
  int sp, n, e;
  // pull-up on the shared power-ok line
  wire power_ok_in = !((power_ok_oe && !power_ok_out) || ext_low);

  pspc_sequencer #(.HICCUP_CNT(50)) DUT (.clk_sys, .arst_n, .mclk_tick, .turn_on_req,
    .status_clear, .start_delay, .stop_delay, .ramp_rate_rise, .ramp_rate_fall, .vout_setpoint,
    .protection_config_one, .protection_config_two, .protection_config_three, .current_limit_cfg,
    .vout_meas, .prebias_meas, .current_at_limit, .temp_meas, .power_ok_in, .power_ok_out,
    .power_ok_oe, .setpoint_ramp, .switches_on, .tcomp_enable, .fault_flag, .alert_out,
    .steady_state);
  pspc_mgr_model #(.TICK_DIV(DIV)) mgr (.clk_sys, .arst_n, .mclk_tick, .turn_on_req,
    .status_clear, .setpoint_ramp, .switches_on, .vout_meas);

  always #12.5 clk_sys = ~clk_sys;

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  task automatic wait_on(input bit sel, input logic want, output int c);
    c = 0;
    while ((sel ? steady_state : switches_on) !== want && c < 4000) begin
      @(negedge clk_sys);
      c++;
    end
    if (c >= 4000) chk(1'b0, "wait limit");
  endtask

  // expected window verdict: 0 inside, 1 outside, 2 on an edge
  function automatic int pg_exp(int v, logic l95);
    int lo = sp * (l95 ? 95 : 90);
    if (v * 100 == sp * 110 || v * 100 == lo) return 2;
    return int'(v * 100 > sp * 110 || v * 100 < lo);
  endfunction

  task automatic go_on(input bit timed);
    int c1, c2;
    mgr.set_on(1'b1);
    wait_on(0, 1'b1, c1);
    if (timed) chk(c1 <= (start_delay + 2) * DIV && c1 + 2 * DIV >= start_delay * DIV,
      "start delay");
    wait_on(1, 1'b1, c2);
    chk(setpoint_ramp === vout_setpoint, "ramp end");
    chk(c2 + 2 * DIV >= sp * ramp_rate_rise * DIV &&
      c2 <= (sp * ramp_rate_rise + 2) * DIV, "ramp time");
  endtask

  initial begin
    #(60000 * 25);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    n = $urandom(46291);
    sp = $urandom_range(40, 16);
    vout_setpoint = VW'(sp);
    start_delay = DW'($urandom_range(7, 2));
    stop_delay = DW'(sp + $urandom_range(12, 4));
    {ramp_rate_rise, ramp_rate_fall} = {16'h0001, 16'h0001};
    {protection_config_one, protection_config_two} = {8'h10, 8'hD0};
    {protection_config_three, current_limit_cfg} = {8'h03, 8'h80};
    repeat (4) @(posedge clk_sys);
    chk(fault_flag === FLAGS_RESET && switches_on === 1'b0, "reset state");
    @(negedge clk_sys);
    arst_n = 1'b1;
    cyc(2);
    chk(tcomp_enable === 1'b1 && fault_flag === FLAGS_RESET, "after reset");
    // ********
    // turn-off without and with falling slew
    // ********
    for (int f = 0; f < 2; f++) begin
      ramp_rate_fall = DW'(f);
      go_on(1);
      mgr.set_on(1'b0);
      wait_on(0, 1'b0, n);
      chk(n <= (stop_delay + 2) * DIV && n + 2 * DIV >= stop_delay * DIV, "stop");
      chk(setpoint_ramp === 9'h000, "ramp at zero");
    end
    // ********
    // power good window, random offsets
    // ********
    go_on(1);
    cyc(2);
    chk(power_ok_oe === 1'b0 && power_ok_out === 1'b0 && fault_flag[FL_PG] === 1'b1,
      "pg inside");
    for (int i = 0; i < 12; i++) begin
      protection_config_two[7] = i[0];
      protection_config_three[CFG3_PG_REPORT] = i[1];
      mgr.offs = int'($urandom_range(2 * sp / 7, 0)) - sp / 7;
      cyc(3);
      e = pg_exp(sp + mgr.offs, i[0]);
      if (e != 2) chk(fault_flag[FL_PG] === (e == 0) && power_ok_oe === (e == 1) &&
        alert_out === (e == 1 && i[1] == 1'b1), "pg window");
    end
    mgr.offs = 0;
    protection_config_three = 8'h03;
    ext_low = 1'b1;
    cyc(3);
    chk(fault_flag[FL_PG] === 1'b0, "external pull");
    ext_low = 1'b0;
    // ********
    // overtemperature, non-latching, restarts below 110
    // ********
    temp_meas = 8'sh79;
    cyc(2);
    chk(fault_flag[FL_OT] === 1'b0 && switches_on === 1'b1, "ot regular");
    temp_meas = 8'sh73;
    wait_on(0, 1'b0, n);
    cyc(200);
    chk(switches_on === 1'b0 && fault_flag[FL_PT] === 1'b1, "ot hold");
    temp_meas = 8'sh64;
    go_on(1);
    chk(fault_flag === FLAGS_RESET, "restart flags");
    // ********
    // undervoltage in steady state
    // ********
    mgr.offs = -sp / 2;
    cyc(2);
    chk(fault_flag[FL_UV] === 1'b0 && fault_flag[FL_OC] === 1'b1 && switches_on === 1'b1,
      "uv regular");
    mgr.offs = 0;
    wait_on(0, 1'b0, n);
    go_on(0);
    // ********
    // tracking disabled, then enabled
    // ********
    mgr.set_on(1'b0);
    wait_on(0, 1'b0, n);
    protection_config_one = 8'h00;
    ramp_rate_rise = 16'h0002;
    current_limit_cfg = 8'h00;
    mgr.offs = 25;
    go_on(1);
    chk(fault_flag[FL_TR] === 1'b1, "tracking off");
    chk(tcomp_enable === 1'b0, "tcomp off");
    mgr.set_on(1'b0);
    wait_on(0, 1'b0, n);
    protection_config_one = 8'h10;
    mgr.set_on(1'b1);
    wait_on(0, 1'b1, n);
    wait_on(0, 1'b0, n);
    chk(n < 4 && fault_flag[FL_TR] === 1'b0 && setpoint_ramp === 9'h000, "track");
    mgr.offs = 0;
    go_on(0);
    // ********
    // overcurrent, latching, released by clear
    // ********
    protection_config_one = 8'h11;
    current_at_limit = 1'b1;
    mgr.offs = -sp / 2;
    cyc(2);
    chk(fault_flag[FL_OC] === 1'b0 && fault_flag[FL_UV] === 1'b1 && switches_on === 1'b0 &&
      setpoint_ramp === 9'h000, "oc fast off");
    current_at_limit = 1'b0;
    mgr.offs = 0;
    cyc(300);
    chk(switches_on === 1'b0 && fault_flag[FL_OC] === 1'b0, "latched");
    mgr.clear_pulse();
    go_on(1);
    chk(fault_flag === FLAGS_RESET, "cleared");
    tally_and_finish();
  end
endmodule
